// file: design/fbs_pkg.sv
// Package with the register map, field layout and timing constants of the master statistics block.
package fbs_pkg;

    // ------------------------------------------------------------
    // Widths and clock timing
    // ------------------------------------------------------------
    localparam int DATA_W = 32;              // Bus and counter width.
    localparam int ADDR_W = 8;               // Decoded byte address width.
    localparam int NUM_CNT = 11;             // Number of event counters.
    localparam int NUM_CYC = 2;              // Number of process-data cycles.
    localparam int CLK_PERIOD_NS = 8;        // Clock period at 125 MHz, in ns.
    localparam logic [DATA_W-1:0] NS_PER_TICK = DATA_W'(CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // Counter indices, in register order
    // ------------------------------------------------------------
    localparam int CNT_TIMEOUT = 0;          // Frame reception timeouts.
    localparam int CNT_OVERFLOW = 1;         // Frames lost to buffer overflow.
    localparam int CNT_FOREIGN = 2;          // Frames of a foreign type.
    localparam int CNT_LINK_OFF = 3;         // Link loss detections.
    localparam int CNT_PD_DISCARD = 4;       // Discarded process data packets.
    localparam int CNT_MBX_DISCARD = 5;      // Discarded mailbox messages.
    localparam int CNT_CRC = 6;              // Frames with a bad check sequence.
    localparam int CNT_RX_ERR = 7;           // Frames flagged bad by the receiver.
    localparam int CNT_COLLISION = 8;        // Late collisions.
    localparam int CNT_SHORT = 9;            // Frames below minimum length.
    localparam int CNT_OVERLEN = 10;         // Frames above maximum length.

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;      // Control and configuration.
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;    // Validity flags.
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h08;  // Sticky event bits, cleared by read.
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h0c;  // Event enable mask.
    localparam logic [ADDR_W-1:0] ADDR_CNT_BASE = 8'h10;  // First counter.
    localparam logic [ADDR_W-1:0] ADDR_PROP = 8'h3c;      // Propagation delay in ns.
    localparam logic [ADDR_W-1:0] ADDR_CYC_BASE = 8'h40;  // Cycle 1 block; cycle 2 follows.
    localparam logic [ADDR_W-1:0] CYC_STRIDE = 8'h10;     // Size of one cycle block.

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_CLEAR = 0;           // Write 1: clear the statistics.
    localparam int CTRL_DC_PRIMARY = 1;      // Clock-capable slave on primary task.
    localparam int CTRL_TASK5_PRESENT = 2;   // Priority-5 task exists.
    localparam int CTRL_TASK5_DC = 3;        // Clock-capable slave on priority-5 task.
    localparam int CTRL_W = 4;               // Stored control bits.
    localparam int STAT_V1 = 0;              // Delay and cycle 1 values valid.
    localparam int STAT_V2 = 1;              // Cycle 2 values valid.

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;
    localparam logic [CTRL_W-1:0] RST_CTRL = 4'h0;
    localparam logic [NUM_CNT-1:0] RST_EVT = 11'h000;

endpackage : fbs_pkg

// file: design/fbs_stats.sv
// Master port frame statistics block with an AHB-Lite register slave and interrupt.
`timescale 1ns/100ps

module fbs_stats
    import fbs_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic reset_n_i,
    // AHB-Lite slave.
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Receive and link event pulses from the MAC, same clock.
    input wire logic rx_timeout_i,
    input wire logic rx_overflow_i,
    input wire logic rx_foreign_i,
    input wire logic link_off_i,
    input wire logic pd_discard_i,
    input wire logic mbx_discard_i,
    input wire logic rx_crc_err_i,
    input wire logic rx_err_i,
    input wire logic late_collision_i,
    input wire logic rx_short_i,
    input wire logic rx_overlength_i,
    // Propagation delay measurement.
    input wire logic prop_delay_valid_i,
    input wire logic [31:0] prop_delay_ns_i,
    // Process-data cycle start pulses, bit 0 for cycle 1.
    input wire logic [1:0] cycle_start_i,
    // Interrupt.
    output logic irq_o
);

    // ------------------------------------------------------------
    // Bus address phase capture
    // ------------------------------------------------------------

    // An address phase is taken when the slave is selected, the bus is ready and htrans_i is NONSEQ or SEQ.
    wire addr_take = hsel_i & hready_i & htrans_i[1];
    wire [ADDR_W-1:0] addr_now = haddr_i[ADDR_W-1:0];
    wire rd_take = addr_take & ~hwrite_i;
    logic wr_pend;                           // A write data phase is under way.
    logic [ADDR_W-1:0] wr_addr;              // Address of that write.

    // The slave never stalls, so every data phase lasts one cycle.
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    // Hold the write address for the data phase that follows.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
        end else begin
            wr_pend <= addr_take & hwrite_i;
            wr_addr <= addr_now;
        end
    end

    // Write strobes, qualified by the data phase.
    wire wr_ctrl = wr_pend && (wr_addr == ADDR_CTRL);
    wire wr_mask = wr_pend && (wr_addr == ADDR_IRQ_MASK);

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------

    logic [CTRL_W-1:0] ctrl;                 // Stored configuration bits.
    logic clear_pulse;                       // One-cycle statistics clear.
    logic [NUM_CNT-1:0] irq_mask;            // Enabled events.

    // The clear bit does not store; it fires a single pulse after the write.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            ctrl <= RST_CTRL;
            clear_pulse <= 1'b0;
            irq_mask <= RST_EVT;
        end else begin
            clear_pulse <= wr_ctrl & hwdata_i[CTRL_CLEAR];
            if (wr_ctrl) begin
                ctrl <= {hwdata_i[CTRL_TASK5_DC:CTRL_DC_PRIMARY], 1'b0};
            end
            if (wr_mask) begin
                irq_mask <= hwdata_i[NUM_CNT-1:0];
            end
        end
    end

    // Validity follows the task assignment that software reports.
    wire valid_1 = ctrl[CTRL_DC_PRIMARY];
    wire valid_2 = ctrl[CTRL_TASK5_PRESENT] & ctrl[CTRL_TASK5_DC];

    // ------------------------------------------------------------
    // Event counters
    // ------------------------------------------------------------

    // Timeout also advances with the three corrupted-frame counters.
    wire to_evt = rx_timeout_i | rx_crc_err_i | rx_short_i | rx_overlength_i;
    wire [NUM_CNT-1:0] evt = {rx_overlength_i, rx_short_i, late_collision_i,
                              rx_err_i, rx_crc_err_i, mbx_discard_i,
                              pd_discard_i, link_off_i, rx_foreign_i,
                              rx_overflow_i, to_evt};
    logic [DATA_W-1:0] cnt [NUM_CNT];        // Counter values.

    // Each counter moves by a whole word in one edge, so a read never sees half an update.
    // A clear in the same cycle as an event keeps that event as a count of one.
    genvar gc;
    generate
        for (gc = 0; gc < NUM_CNT; gc++) begin : g_cnt
            wire [DATA_W-1:0] next_cnt = clear_pulse ? RST_WORD : cnt[gc];
            always_ff @(posedge clk_i) begin
                if (!reset_n_i) begin
                    cnt[gc] <= RST_WORD;
                end else begin
                    cnt[gc] <= evt[gc] ? next_cnt + 32'h1 : next_cnt;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Propagation delay
    // ------------------------------------------------------------

    logic [DATA_W-1:0] prop_delay;           // Last measured delay in ns.

    // The clear pulse is deliberately not seen here.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            prop_delay <= RST_WORD;
        end else if (prop_delay_valid_i) begin
            prop_delay <= prop_delay_ns_i;
        end
    end

    // ------------------------------------------------------------
    // Cycle time measurement
    // ------------------------------------------------------------

    logic [DATA_W-1:0] cyc_cur [NUM_CYC];    // Latest period in ns.
    logic [DATA_W-1:0] cyc_max [NUM_CYC];    // Longest period in ns.
    logic [DATA_W-1:0] cyc_min [NUM_CYC];    // Shortest period in ns.
    logic [DATA_W-1:0] cyc_jit [NUM_CYC];    // Change between last two periods in ns.
    logic [NUM_CYC-1:0] meas_stb;            // A new period was taken.

    // Ticks run from one start pulse to the next; the period is ticks plus one, times the clock period.
    // Resolution is one clock period, 8 ns; a saturated tick count marks a stalled cycle.
    genvar gy;
    generate
        for (gy = 0; gy < NUM_CYC; gy++) begin : g_cyc
            logic [DATA_W-1:0] ticks;        // Clocks since the last start.
            logic started;                   // A first start has been seen.
            logic have_meas;                 // Min and jitter hold a real value.
            wire [DATA_W-1:0] period = (ticks + 32'h1) * NS_PER_TICK;
            wire [DATA_W-1:0] delta = (period >= cyc_cur[gy]) ? period - cyc_cur[gy] : cyc_cur[gy] - period;
            wire take = cycle_start_i[gy] & started;
            wire [DATA_W-1:0] next_max = (!have_meas || period > cyc_max[gy]) ? period : cyc_max[gy];
            wire [DATA_W-1:0] next_min = (!have_meas || period < cyc_min[gy]) ? period : cyc_min[gy];
            wire [DATA_W-1:0] next_jit = have_meas ? delta : RST_WORD;

            // Free-running tick counter, restarted by each cycle start.
            always_ff @(posedge clk_i) begin
                if (!reset_n_i) begin
                    ticks <= RST_WORD;
                    started <= 1'b0;
                end else if (cycle_start_i[gy]) begin
                    ticks <= RST_WORD;
                    started <= 1'b1;
                end else if (ticks != '1) begin
                    ticks <= ticks + 32'h1;
                end
            end

            // Current, max, min and jitter update together on each period.
            always_ff @(posedge clk_i) begin
                if (!reset_n_i || clear_pulse) begin
                    cyc_cur[gy] <= RST_WORD;
                    cyc_max[gy] <= RST_WORD;
                    cyc_min[gy] <= RST_WORD;
                    cyc_jit[gy] <= RST_WORD;
                    have_meas <= 1'b0;
                    meas_stb[gy] <= 1'b0;
                end else begin
                    meas_stb[gy] <= take;
                    if (take) begin
                        cyc_cur[gy] <= period;
                        cyc_max[gy] <= next_max;
                        cyc_min[gy] <= next_min;
                        cyc_jit[gy] <= next_jit;
                        have_meas <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------

    logic [NUM_CNT-1:0] irq_stat;            // Sticky event bits.
    wire rd_irq = rd_take && (addr_now == ADDR_IRQ_STAT);

    // A read clears the bits it returned; an event in the same cycle still sets its bit.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            irq_stat <= RST_EVT;
        end else begin
            irq_stat <= (rd_irq ? RST_EVT : irq_stat) | evt;
        end
    end

    assign irq_o = |(irq_stat & irq_mask);

    // ------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------

    // Word index of an address within a block, or all ones when outside it.
    function automatic logic [ADDR_W-1:0] word_in(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] base,
                                                  input int words);
        logic [ADDR_W-1:0] off;
        off = a - base;
        word_in = (a >= base && off[1:0] == 2'b00 && (off >> 2) < ADDR_W'(words)) ? (off >> 2) : '1;
    endfunction

    wire [ADDR_W-1:0] cnt_idx = word_in(addr_now, ADDR_CNT_BASE, NUM_CNT);
    wire [ADDR_W-1:0] cyc_idx = word_in(addr_now, ADDR_CYC_BASE, 2 * NUM_CYC * 2);
    wire cyc_sel = cyc_idx[2];
    logic [DATA_W-1:0] rd_word;

    // Unmapped addresses read as zero and still answer OKAY.
    always_comb begin
        rd_word = RST_WORD;
        if (addr_now == ADDR_CTRL) begin
            rd_word = DATA_W'({ctrl[CTRL_TASK5_DC:CTRL_DC_PRIMARY], 1'b0});
        end else if (addr_now == ADDR_STATUS) begin
            rd_word = DATA_W'({valid_2, valid_1});
        end else if (addr_now == ADDR_IRQ_STAT) begin
            rd_word = DATA_W'(irq_stat);
        end else if (addr_now == ADDR_IRQ_MASK) begin
            rd_word = DATA_W'(irq_mask);
        end else if (cnt_idx != '1) begin
            rd_word = cnt[cnt_idx[3:0]];
        end else if (addr_now == ADDR_PROP) begin
            rd_word = prop_delay;
        end else if (cyc_idx != '1) begin
            case (cyc_idx[1:0])
                2'h0: rd_word = cyc_cur[cyc_sel];
                2'h1: rd_word = cyc_max[cyc_sel];
                2'h2: rd_word = cyc_min[cyc_sel];
                default: rd_word = cyc_jit[cyc_sel];
            endcase
        end
    end

    // The word is caught at the address edge, a whole snapshot for the data phase.
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            hrdata_o <= RST_WORD;
        end else if (rd_take) begin
            hrdata_o <= rd_word;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    a_reset_zeroes: assert property (disable iff (1'b0)
        !reset_n_i |=> (cnt[CNT_CRC] == RST_WORD && prop_delay == RST_WORD))
        else $error("Reset did not zero the statistics.");
    a_clear_keeps_delay: assert property (
        clear_pulse && !prop_delay_valid_i |=> prop_delay == $past(prop_delay))
        else $error("Clear changed the propagation delay.");
    a_status_v1: assert property (
        rd_take && addr_now == ADDR_STATUS |=> hrdata_o[STAT_V1] == $past(ctrl[CTRL_DC_PRIMARY]))
        else $error("Delay validity flag wrong.");
    a_status_v2: assert property (
        rd_take && addr_now == ADDR_STATUS |=>
        hrdata_o[STAT_V2] == $past(ctrl[CTRL_TASK5_PRESENT] && ctrl[CTRL_TASK5_DC]))
        else $error("Cycle 2 validity flag wrong.");
    a_cycle_order: assert property (
        meas_stb[0] |-> cyc_min[0] <= cyc_cur[0] && cyc_cur[0] <= cyc_max[0])
        else $error("Cycle 1 min, current and max out of order.");
    a_timeout_follow: assert property (
        rx_crc_err_i && !clear_pulse |=> cnt[CNT_TIMEOUT] == $past(cnt[CNT_TIMEOUT]) + 32'h1)
        else $error("Timeout counter missed a CRC error.");
    a_overflow_count: assert property (
        rx_overflow_i && !clear_pulse |=> cnt[CNT_OVERFLOW] == $past(cnt[CNT_OVERFLOW]) + 32'h1)
        else $error("Overflow counter did not advance.");
    a_foreign_count: assert property (
        !rx_foreign_i && !clear_pulse |=> cnt[CNT_FOREIGN] == $past(cnt[CNT_FOREIGN]))
        else $error("Foreign frame counter moved without an event.");
    // Both event cycles must be free of a clear, or the two-cycle sum would not hold.
    a_pd_count: assert property (
        (pd_discard_i && !clear_pulse) ##1 (pd_discard_i && !clear_pulse) |=>
        cnt[CNT_PD_DISCARD] == $past(cnt[CNT_PD_DISCARD], 2) + 32'h2)
        else $error("Process data discard counter missed an event.");
    a_mbx_count: assert property (
        mbx_discard_i && !clear_pulse |=> cnt[CNT_MBX_DISCARD] == $past(cnt[CNT_MBX_DISCARD]) + 32'h1)
        else $error("Mailbox discard counter did not advance.");
    a_crc_count: assert property (
        rx_crc_err_i && !clear_pulse |=> cnt[CNT_CRC] == $past(cnt[CNT_CRC]) + 32'h1)
        else $error("CRC counter did not advance.");
    a_coll_count: assert property (
        late_collision_i && !clear_pulse |=> cnt[CNT_COLLISION] == $past(cnt[CNT_COLLISION]) + 32'h1)
        else $error("Collision counter did not advance.");
    a_clear_zeroes: assert property (
        wr_ctrl && hwdata_i[CTRL_CLEAR] ##1 !rx_short_i |=> cnt[CNT_SHORT] == RST_WORD && cyc_max[1] == RST_WORD)
        else $error("Clear left statistics non-zero.");
    a_read_snapshot: assert property (
        rd_take && cnt_idx == 8'h0 |=> hrdata_o == $past(cnt[CNT_TIMEOUT]))
        else $error("Counter read was not a whole snapshot.");

    c_clear: cover property (clear_pulse ##1 rx_timeout_i);
    c_meas_both: cover property (meas_stb[0] && meas_stb[1]);
    c_irq: cover property ($rose(irq_o) ##[1:20] rd_irq);
    c_event_on_clear: cover property (clear_pulse && rx_crc_err_i);

endmodule // fbs_stats

// file: bench/fbs_line_model.sv
// Behavioural model of the slave line side: receive events, delay results and cycle starts.
`timescale 1ns/100ps
module fbs_line_model (
    // Clock.
    input wire logic clk_i,
    // Line-side pulses.
    output logic [10:0] evt_o,
    output logic delay_valid_o,
    output logic [31:0] delay_ns_o,
    output logic [1:0] cyc_o
);
    // ------------------------------------------------------------
    // Idle state
    // ------------------------------------------------------------
    // All strobes rest low between uses.
    initial begin
        evt_o = 11'h000;
        delay_valid_o = 1'b0;
        delay_ns_o = 32'h0;
        cyc_o = 2'h0;
    end
    // ------------------------------------------------------------
    // Stimulus tasks
    // ------------------------------------------------------------
    // Hold one event line high for n cycles in a row; each high cycle is one frame.
    task automatic send_evt(input int idx, input int n);
        @(posedge clk_i);
        evt_o[idx] <= 1'b1;
        repeat (n) @(posedge clk_i);
        evt_o[idx] <= 1'b0;
    endtask
    // Report one delay result; the word is inverted once released so stale data never looks fresh.
    task automatic load_delay(input logic [31:0] v);
        @(posedge clk_i);
        delay_valid_o <= 1'b1;
        delay_ns_o <= v;
        @(posedge clk_i);
        delay_valid_o <= 1'b0;
        delay_ns_o <= ~v;
    endtask
    // Three cycle starts, g1 and then g2 clocks apart.
    task automatic run(input logic [1:0] m, input int g1, input int g2);
        @(posedge clk_i);
        cyc_o <= m;
        @(posedge clk_i);
        cyc_o <= 2'h0;
        repeat (g1 - 1) @(posedge clk_i);
        cyc_o <= m;
        @(posedge clk_i);
        cyc_o <= 2'h0;
        repeat (g2 - 1) @(posedge clk_i);
        cyc_o <= m;
        @(posedge clk_i);
        cyc_o <= 2'h0;
    endtask
endmodule // fbs_line_model

// file: bench/fbs_stats_bench.sv
// Self-checking bench for the master frame statistics block.
`timescale 1ns/100ps
module fbs_stats_bench
    import fbs_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk_i;
    logic reset_n_i;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hready; // Single slave: its hreadyout is the bus hready.
    logic hresp;
    logic irq;
    logic [10:0] evt;
    logic dly_valid;
    logic [31:0] dly_ns;
    logic [1:0] cyc;
    int fail_count;
    int checked;
    logic [31:0] exp_cnt [NUM_CNT];
    localparam logic [31:0] CTRL_TAB [5] = '{32'h2, 32'h4, 32'h8, 32'hc, 32'he};
    localparam logic [31:0] STAT_TAB [5] = '{32'h1, 32'h0, 32'h0, 32'h2, 32'h3};

    fbs_stats u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .rx_timeout_i(evt[0]), .rx_overflow_i(evt[1]),
        .rx_foreign_i(evt[2]), .link_off_i(evt[3]), .pd_discard_i(evt[4]), .mbx_discard_i(evt[5]),
        .rx_crc_err_i(evt[6]), .rx_err_i(evt[7]), .late_collision_i(evt[8]), .rx_short_i(evt[9]),
        .rx_overlength_i(evt[10]), .prop_delay_valid_i(dly_valid), .prop_delay_ns_i(dly_ns),
        .cycle_start_i(cyc), .irq_o(irq));
    fbs_line_model u_line (.clk_i(clk_i), .evt_o(evt), .delay_valid_o(dly_valid), .delay_ns_o(dly_ns),
        .cyc_o(cyc));

    // 125 MHz clock.
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------
    // Check and bus tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic print_verdict();
        $display("Counts: %0d compared, %0d mismatched", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Wait for hready under a bound, so a stuck slave ends the run instead of hanging it.
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge clk_i);
        while (hready !== 1'b1) begin
            n++;
            if (n > 16) begin
                fail_count++;
                print_verdict();
            end
            @(posedge clk_i);
        end
    endtask
    // One single word transfer; read data is taken at the edge that ends the data phase.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rv);
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rv = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask
    // Two idle edges let a write, and a clear it starts, land before anything is read.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        bus(1'b1, a, d, v);
        repeat (2) @(posedge clk_i);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] want);
        logic [31:0] v;
        bus(1'b0, a, 32'h0, v);
        check(v, want);
    endtask
    // The interrupt is read a little after the edge, once register updates have settled.
    task automatic irq_chk(input logic want);
        #1;
        check({31'h0, irq}, {31'h0, want});
    endtask
    task automatic cnt_chk();
        for (int j = 0; j < NUM_CNT; j++) rd_chk(ADDR_CNT_BASE + 8'(4 * j), exp_cnt[j]);
    endtask
    // Reads one cycle block: current, maximum, minimum, jitter.
    task automatic cyc_chk(input int c, input int cur, input int mx, input int mn, input int jt);
        rd_chk(ADDR_CYC_BASE + 8'(16 * c), 32'(cur));
        rd_chk(ADDR_CYC_BASE + 8'(16 * c) + 8'h4, 32'(mx));
        rd_chk(ADDR_CYC_BASE + 8'(16 * c) + 8'h8, 32'(mn));
        rd_chk(ADDR_CYC_BASE + 8'(16 * c) + 8'hc, 32'(jt));
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        reset_n_i = 1'b0;
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        fail_count = 0;
        checked = 0;
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        irq_chk(1'b0);
        for (int i = 0; i < 24; i++) rd_chk(8'(4 * i), 32'h0);
        $display("Test reset values done");
        // Every counter in turn, with runs of back-to-back frames; all counters are reread each time.
        for (int i = 0; i < NUM_CNT; i++) begin
            exp_cnt[i] = 32'h0;
        end
        for (int i = 0; i < NUM_CNT; i++) begin
            u_line.send_evt(i, i + 1);
            exp_cnt[i] += 32'(i + 1);
            if (i == CNT_CRC || i == CNT_SHORT || i == CNT_OVERLEN) exp_cnt[CNT_TIMEOUT] += 32'(i + 1);
            cnt_chk();
        end
        $display("Test event counters done");
        irq_chk(1'b0);
        wr(ADDR_IRQ_MASK, 32'h40);
        irq_chk(1'b1);
        rd_chk(ADDR_IRQ_STAT, 32'h7ff);
        irq_chk(1'b0);
        u_line.send_evt(CNT_FOREIGN, 1);
        irq_chk(1'b0);
        u_line.send_evt(CNT_CRC, 1);
        irq_chk(1'b1);
        rd_chk(ADDR_IRQ_STAT, 32'h45);
        rd_chk(ADDR_IRQ_STAT, 32'h0);
        $display("Test interrupt done");
        // Validity flags for five task arrangements; status and unmapped places ignore writes.
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_CTRL, CTRL_TAB[i]);
            rd_chk(ADDR_CTRL, CTRL_TAB[i]);
            rd_chk(ADDR_STATUS, STAT_TAB[i]);
        end
        wr(ADDR_STATUS, 32'h0);
        rd_chk(ADDR_STATUS, 32'h3);
        wr(8'h80, 32'hffff_ffff);
        rd_chk(8'h80, 32'h0);
        $display("Test validity flags done");
        u_line.load_delay(32'h1234);
        u_line.run(2'h3, 10, 12);
        cyc_chk(0, 96, 96, 80, 16);
        cyc_chk(1, 96, 96, 80, 16);
        rd_chk(ADDR_PROP, 32'h1234);
        $display("Test cycle timing done");
        // Clear zeroes the counters and cycle values, not the delay; mask survives and the next measurement reseeds.
        wr(ADDR_CTRL, 32'h1);
        for (int j = 0; j < NUM_CNT; j++) begin
            exp_cnt[j] = 32'h0;
        end
        cnt_chk();
        cyc_chk(0, 0, 0, 0, 0);
        cyc_chk(1, 0, 0, 0, 0);
        rd_chk(ADDR_PROP, 32'h1234);
        rd_chk(ADDR_CTRL, 32'h0);
        rd_chk(ADDR_IRQ_MASK, 32'h40);
        u_line.send_evt(CNT_OVERFLOW, 1);
        rd_chk(ADDR_CNT_BASE + 8'h4, 32'h1);
        // The tick counter is not re-armed by a clear, so the first period after it spans the clear.
        // A start just before the clear keeps that spanning period short and known: six clocks, 48 ns.
        u_line.run(2'h1, 5, 5);
        wr(ADDR_CTRL, 32'h1);
        u_line.run(2'h1, 5, 5);
        cyc_chk(0, 40, 48, 40, 0);
        $display("Test clear done");
        print_verdict();
    end
endmodule // fbs_stats_bench
